// *** pmc_pkg.sv ***
// Package: register map, field positions, reset values and timing of the polling-mode control bank
`default_nettype none
package pmc_pkg;
    // Register offsets
    localparam logic [7:0] PMC_ADDR_ON_TIME_B_LO = 8'h9e;
    localparam logic [7:0] PMC_ADDR_ON_TIME_B_HI = 8'h9f;
    localparam logic [7:0] PMC_ADDR_REF_TIMER    = 8'h99;
    localparam logic [7:0] PMC_ADDR_EXT_CMD      = 8'ha4;
    localparam logic [7:0] PMC_ADDR_CMC_SECOND   = 8'ha5;
    localparam logic [7:0] PMC_ADDR_CTRL         = 8'hb0;
    localparam logic [7:0] PMC_ADDR_STATUS       = 8'hb1;

    // Reset values
    localparam logic [7:0] PMC_RST_ON_TIME_B_LO = 8'h01;
    localparam logic [7:0] PMC_RST_ON_TIME_B_HI = 8'h00;
    localparam logic [7:0] PMC_RST_REF_TIMER    = 8'h01;
    localparam logic [7:0] PMC_RST_EXT_CMD      = 8'h00;
    localparam logic [7:0] PMC_RST_CMC_SECOND   = 8'h04;
    localparam logic [7:0] PMC_RST_CTRL         = 8'h00;

    // Command register bits
    localparam int PMC_CMD_GAIN_FRZ = 3;
    localparam int PMC_CMD_FREQ_FRZ = 2;
    localparam int PMC_CMD_TIMEOUT  = 1;
    localparam int PMC_CMD_MSG_END  = 0;

    // Second chip-mode register bits
    localparam int PMC_CMC_NEXT_AFTER_END = 5;
    localparam int PMC_CMC_NEXT_AFTER_TO  = 4;
    localparam int PMC_CMC_CYCLE_INIT     = 3;
    localparam int PMC_CMC_FRAME_INIT     = 2;
    localparam int PMC_CMC_FIFO_LOCK      = 1;
    localparam int PMC_CMC_XTAL_PREC      = 0;

    // Own control register bits
    localparam int PMC_CTL_SELF_POLL   = 0;
    localparam int PMC_CTL_CFG_SEL     = 1;
    localparam int PMC_CTL_GAIN_SRC    = 2;
    localparam int PMC_CTL_FREQ_SRC    = 3;
    localparam int PMC_CTL_EXT_SEL_LSB = 4;
    localparam int PMC_CTL_LOCK_REL    = 6;

    // Timing
    localparam int PMC_ON_TIME_W      = 14;
    localparam int PMC_PRESCALE_W     = 6;
    localparam logic [5:0] PMC_PRESCALE_LAST = 6'h3f;

    typedef enum logic [1:0]
    {
        PMC_ST_IDLE = 2'b00,
        PMC_ST_POLL = 2'b01,
        PMC_ST_RUN  = 2'b10
    } pmc_state_e;

    typedef struct packed
    {
        logic message_end;
        logic timeout;
        logic wake_found;
        logic frame_start;
        logic cycle_start;
    } pmc_evt_s;
endpackage
`default_nettype wire

// *** pmc_unit_tick.sv ***
// Polling time unit generator: 64 clocks times the reference setting
`default_nettype none
module pmc_unit_tick
    import pmc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // Setting
    input  wire logic [7:0] ref_setting_i,
    output logic            unit_tick_o
);
    logic [PMC_PRESCALE_W-1:0] pre;
    logic [7:0]                units;
    logic                      pre_tick;

    assign pre_tick = (pre == PMC_PRESCALE_LAST);

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pre <= '0;
        else
            pre <= pre + 1'b1;
    end

    // Setting zero wraps through 256 prescale ticks
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            units       <= '0;
            unit_tick_o <= 1'b0;
        end
        else
        begin
            unit_tick_o <= 1'b0;
            if (pre_tick)
            begin
                if (units + 8'h01 == ref_setting_i)
                begin
                    units       <= '0;
                    unit_tick_o <= 1'b1;
                end
                else
                    units <= units + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// *** pmc_on_timer.sv ***
// On-time counter in polling time units; zero load means 16384 units
`default_nettype none
module pmc_on_timer
    import pmc_pkg::*;
#(
    parameter int W = PMC_ON_TIME_W
)
(
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // Control
    input  wire logic         start_i,
    input  wire logic         stop_i,
    input  wire logic         unit_tick_i,
    input  wire logic [W-1:0] load_i,
    output logic              busy_o,
    output logic              done_o
);
    logic [W-1:0] remain;

    // A load of zero counts the full 2^W units since the decrement wraps
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            remain <= '0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            if (start_i)
            begin
                remain <= load_i;
                busy_o <= 1'b1;
            end
            else if (stop_i)
                busy_o <= 1'b0;
            else if (busy_o && unit_tick_i)
            begin
                remain <= remain - 1'b1;
                if (remain == {{(W-1){1'b0}}, 1'b1})
                begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** pmc_regs.sv ***
// Polling-mode chip control registers with configuration sequencing and FIFO control
//
// Design decision made here: the address-and-strobe port.
`default_nettype none
module pmc_regs
    import pmc_pkg::*;
(
    // Clock and reset
    input  wire logic       CORE_CLK_I,
    input  wire logic       RST_N_I,
    // Register port
    input  wire logic [7:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic [7:0]      RDATA_O,
    // Receiver events
    input  wire pmc_evt_s   EVT_I,
    input  wire logic       SLEEP_I,
    // Receiver controls
    output logic            RX_ON_O,
    output logic            CONFIG_B_O,
    output logic            GAIN_FREEZE_O,
    output logic            FREQ_FREEZE_O,
    output logic            TIMEOUT_EVENT_O,
    output logic            MESSAGE_END_EVENT_O,
    output logic            FIFO_INIT_O,
    output logic            FIFO_LOCK_O,
    output logic            XTAL_HP_O
);
    logic [7:0]               on_time_b_lo;
    logic [7:0]               on_time_b_hi;
    logic [7:0]               ref_setting;
    logic [7:0]               ext_cmd;
    logic [7:0]               cmc_second;
    logic [7:0]               ctrl;
    logic [PMC_ON_TIME_W-1:0] config_b_on_time;
    logic [PMC_ON_TIME_W-1:0] on_load;
    logic [1:0]               ext_sel;
    logic                     ext_active;
    logic                     msg_end;
    logic                     timeout;
    logic                     unit_tick;
    logic                     tmr_busy;
    logic                     tmr_done;
    logic                     tmr_start;
    logic                     cfg_b;
    logic                     next_cfg_b;
    logic                     locked;
    logic                     wr_cmd;
    logic                     self_poll;
    logic                     cfg_sel;
    logic                     force_timeout;
    logic                     force_msg_end;
    logic                     init_slave_cycle;
    logic                     init_wake;
    logic                     init_frame;
    logic                     lock_release;
    logic                     next_alt;
    logic                     tmr_stop;
    logic [1:0]               freeze;
    logic [7:0]               status;
    pmc_state_e               state;
    pmc_state_e               next_state;

    assign config_b_on_time = {on_time_b_hi[5:0], on_time_b_lo};
    assign ext_sel          = ctrl[PMC_CTL_EXT_SEL_LSB +: 2];
    assign ext_active       = (ext_sel == 2'd1) || (ext_sel == 2'd2);
    assign wr_cmd           = WR_I && (ADDR_I == PMC_ADDR_EXT_CMD);

    // Control field decode
    assign self_poll        = ctrl[PMC_CTL_SELF_POLL];
    assign cfg_sel          = ctrl[PMC_CTL_CFG_SEL];
    assign force_timeout    = wr_cmd && WDATA_I[PMC_CMD_TIMEOUT] && ext_active;
    assign force_msg_end    = wr_cmd && WDATA_I[PMC_CMD_MSG_END] && ext_active;
    assign lock_release     = WR_I && (ADDR_I == PMC_ADDR_CTRL) && WDATA_I[PMC_CTL_LOCK_REL];
    assign next_alt         = cfg_sel && !cfg_b;
    // Leaving the poll phase aborts the running on-time count
    assign tmr_stop         = (state != PMC_ST_POLL);

    // Forced events are taken in the write cycle and reach the chain next cycle
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            TIMEOUT_EVENT_O     <= 1'b0;
            MESSAGE_END_EVENT_O <= 1'b0;
        end
        else
        begin
            TIMEOUT_EVENT_O     <= EVT_I.timeout
                                   || force_timeout;
            MESSAGE_END_EVENT_O <= EVT_I.message_end
                                   || force_msg_end;
        end
    end

    assign msg_end = MESSAGE_END_EVENT_O;
    assign timeout = TIMEOUT_EVENT_O;

    // Plain registers
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            on_time_b_lo <= PMC_RST_ON_TIME_B_LO;
            on_time_b_hi <= PMC_RST_ON_TIME_B_HI;
            ref_setting  <= PMC_RST_REF_TIMER;
            cmc_second   <= PMC_RST_CMC_SECOND;
            ctrl         <= PMC_RST_CTRL;
        end
        else if (WR_I)
        begin
            unique case (ADDR_I)
                PMC_ADDR_ON_TIME_B_LO: on_time_b_lo <= WDATA_I;
                PMC_ADDR_ON_TIME_B_HI: on_time_b_hi <= {2'b00, WDATA_I[5:0]};
                PMC_ADDR_REF_TIMER:    ref_setting  <= WDATA_I;
                PMC_ADDR_CMC_SECOND:   cmc_second   <= {2'b00, WDATA_I[5:0]};
                PMC_ADDR_CTRL:         ctrl         <= {2'b00, WDATA_I[5:0]};
                default:               ;
            endcase
        end
    end

    // Command strobes: freeze bits hold while written one, event bits self-clear
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            ext_cmd <= PMC_RST_EXT_CMD;
        else if (wr_cmd)
            ext_cmd <= {4'h0, WDATA_I[3:2], 2'b00};
    end

    // Each freeze needs its command bit and its serial-command source bit together
    genvar f;
    generate
        for (f = 0; f < 2; f = f + 1)
        begin : g_freeze
            assign freeze[f] = ext_cmd[PMC_CMD_FREQ_FRZ + f] && ctrl[PMC_CTL_FREQ_SRC - f];
        end
    endgenerate

    assign GAIN_FREEZE_O = freeze[1];
    assign FREQ_FREEZE_O = freeze[0];
    assign status        = {3'h0, locked, tmr_busy, cfg_b, state};

    // Read port: data one cycle after the strobe, unmapped reads zero
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            RDATA_O <= 8'h00;
        else if (RD_I)
        begin
            unique case (ADDR_I)
                PMC_ADDR_ON_TIME_B_LO: RDATA_O <= on_time_b_lo;
                PMC_ADDR_ON_TIME_B_HI: RDATA_O <= on_time_b_hi;
                PMC_ADDR_REF_TIMER:    RDATA_O <= ref_setting;
                PMC_ADDR_EXT_CMD:      RDATA_O <= ext_cmd;
                PMC_ADDR_CMC_SECOND:   RDATA_O <= cmc_second;
                PMC_ADDR_CTRL:         RDATA_O <= ctrl;
                PMC_ADDR_STATUS:       RDATA_O <= status;
                default:               RDATA_O <= 8'h00;
            endcase
        end
        else
            RDATA_O <= 8'h00;
    end

    pmc_unit_tick u_tick
    (
        .clk_i         (CORE_CLK_I),
        .rst_n_i       (RST_N_I),
        .ref_setting_i (ref_setting),
        .unit_tick_o   (unit_tick)
    );

    // Config A on-time lies outside this bank; here it is a fixed load of one polling time unit
    assign on_load = next_cfg_b ? config_b_on_time : {{(PMC_ON_TIME_W-8){1'b0}}, 8'h01};

    pmc_on_timer #(.W(PMC_ON_TIME_W)) u_on
    (
        .clk_i       (CORE_CLK_I),
        .rst_n_i     (RST_N_I),
        .start_i     (tmr_start),
        .stop_i      (tmr_stop),
        .unit_tick_i (unit_tick),
        .load_i      (on_load),
        .busy_o      (tmr_busy),
        .done_o      (tmr_done)
    );

    // Self-polling sequencer
    always_comb
    begin
        next_state = state;
        next_cfg_b = cfg_b;
        tmr_start  = 1'b0;
        unique case (state)
            PMC_ST_IDLE:
            begin
                if (ctrl[PMC_CTL_SELF_POLL])
                begin
                    next_state = PMC_ST_POLL;
                    next_cfg_b = 1'b0;
                    tmr_start  = 1'b1;
                end
            end
            PMC_ST_POLL:
            begin
                if (!ctrl[PMC_CTL_SELF_POLL])
                    next_state = PMC_ST_IDLE;
                else if (EVT_I.wake_found)
                    next_state = PMC_ST_RUN;
                else if (tmr_done)
                begin
                    next_cfg_b = next_alt;
                    tmr_start  = 1'b1;
                end
            end
            PMC_ST_RUN:
            begin
                if (!ctrl[PMC_CTL_SELF_POLL])
                    next_state = PMC_ST_IDLE;
                else if (msg_end || timeout)
                begin
                    next_state = PMC_ST_POLL;
                    tmr_start  = 1'b1;
                    if (msg_end ? cmc_second[PMC_CMC_NEXT_AFTER_END]
                                : cmc_second[PMC_CMC_NEXT_AFTER_TO])
                        next_cfg_b = next_alt;
                    else
                        next_cfg_b = 1'b0;
                end
            end
            default:
                next_state = PMC_ST_IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            state <= PMC_ST_IDLE;
            cfg_b <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cfg_b <= next_cfg_b;
        end
    end

    // In slave mode the selection bit picks the single configuration directly
    assign CONFIG_B_O = self_poll ? cfg_b : cfg_sel;
    assign RX_ON_O    = self_poll ? (tmr_busy || state == PMC_ST_RUN) : !SLEEP_I;

    // Cycle-start init means receive start in slave mode but wake-up in self-polling
    assign init_slave_cycle = cmc_second[PMC_CMC_CYCLE_INIT] && !self_poll
                              && EVT_I.cycle_start;
    assign init_wake        = cmc_second[PMC_CMC_CYCLE_INIT] && (state == PMC_ST_POLL)
                              && (next_state == PMC_ST_RUN);
    assign init_frame       = cmc_second[PMC_CMC_FRAME_INIT] && EVT_I.frame_start;

    // FIFO initialisation pulse
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            FIFO_INIT_O <= 1'b0;
        else
            FIFO_INIT_O <= init_slave_cycle || init_wake || init_frame;
    end

    // Lock holds until software writes the release bit; a new message end wins
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            locked <= 1'b0;
        else if (cmc_second[PMC_CMC_FIFO_LOCK] && msg_end)
            locked <= 1'b1;
        else if (lock_release)
            locked <= 1'b0;
    end

    assign FIFO_LOCK_O = locked;
    // Outside sleep the crystal always runs in full precision
    assign XTAL_HP_O   = SLEEP_I ? cmc_second[PMC_CMC_XTAL_PREC] : 1'b1;
endmodule
`default_nettype wire

// *** pmc_regs_props.sv ***
// Checker for the polling-mode control register bank ports
`default_nettype none
module pmc_regs_props
    import pmc_pkg::*;
(
    input wire logic     CORE_CLK_I,
    input wire logic     RST_N_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic     WR_I,
    input wire logic     RD_I,
    input wire logic [7:0] RDATA_O,
    input wire pmc_evt_s EVT_I,
    input wire logic     SLEEP_I,
    input wire logic     TIMEOUT_EVENT_O,
    input wire logic     MESSAGE_END_EVENT_O,
    input wire logic     GAIN_FREEZE_O,
    input wire logic     FIFO_INIT_O,
    input wire logic     FIFO_LOCK_O,
    input wire logic     XTAL_HP_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);

    // Shadow of the second chip-mode register, so bit-level rules can be tied to writes
    logic [7:0] cmc;
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            cmc <= PMC_RST_CMC_SECOND;
        else if (WR_I && ADDR_I == PMC_ADDR_CMC_SECOND)
            cmc <= WDATA_I & 8'h3f;
    end

    sequence s_rd_cmc;
        RD_I && ADDR_I == PMC_ADDR_CMC_SECOND;
    endsequence
    sequence s_msg_lock;
        MESSAGE_END_EVENT_O && cmc[PMC_CMC_FIFO_LOCK];
    endsequence

    a_read_idle_zero: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
        else $error("read data not zero outside read cycle");
    a_cmc_read_back: assert property (s_rd_cmc |=> RDATA_O == cmc)
        else $error("second chip-mode register read back wrong");
    a_gain_unfrozen: assert property (WR_I && ADDR_I == PMC_ADDR_EXT_CMD && !WDATA_I[3]
        |=> !GAIN_FREEZE_O)
        else $error("gain freeze held after zero command");
    a_timeout_pass: assert property (EVT_I.timeout |=> TIMEOUT_EVENT_O)
        else $error("timeout event not passed on");
    a_msg_end_pass: assert property (EVT_I.message_end |=> MESSAGE_END_EVENT_O)
        else $error("message end event not passed on");
    a_frame_init: assert property (EVT_I.frame_start && cmc[PMC_CMC_FRAME_INIT]
        |=> FIFO_INIT_O)
        else $error("no fifo init at frame start");
    a_lock_set: assert property (s_msg_lock |=> FIFO_LOCK_O)
        else $error("fifo lock not set at message end");
    a_xtal_sleep: assert property (SLEEP_I |-> XTAL_HP_O == cmc[PMC_CMC_XTAL_PREC])
        else $error("crystal precision in sleep wrong");
endmodule
`default_nettype wire

// *** pmc_host.sv ***
// Host model: drives the register port one strobe at a time
`default_nettype none
module pmc_host
(
    input  wire logic       clk_i,
    output logic [7:0]      addr_o,
    output logic [7:0]      wdata_o,
    output logic            wr_o,
    output logic            rd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // Never waits for the slave: every access completes in one cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_o <= 1'b1;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clk_i);
        wr_o <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        rd_o <= 1'b1;
        addr_o <= a;
        @(posedge clk_i);
        rd_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** polling_mode_chip_control_regs_tb_top.sv ***
// Testbench for the polling-mode control register bank
`default_nettype none
module polling_mode_chip_control_regs_tb_top;
    import pmc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr, wdata, rdata;
    logic wr, rd, sleep = 1'b0, rd_d = 1'b0;
    pmc_evt_s evt = '0;
    logic rx_on, cfg_b, gfrz, ffrz, to_ev, me_ev, finit, flock, xtal;
    logic [7:0] qe[$];
    logic [7:0] r0, r1;
    int mismatches = 0, n_checks = 0, cyc = 0, seen_b;
    always #10 clk = ~clk;
    pmc_host pmc_host_inst (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    pmc_regs pmc_regs_inst (.CORE_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .EVT_I(evt), .SLEEP_I(sleep), .RX_ON_O(rx_on),
        .CONFIG_B_O(cfg_b), .GAIN_FREEZE_O(gfrz), .FREQ_FREEZE_O(ffrz),
        .TIMEOUT_EVENT_O(to_ev), .MESSAGE_END_EVENT_O(me_ev), .FIFO_INIT_O(finit),
        .FIFO_LOCK_O(flock), .XTAL_HP_O(xtal));
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rdx(input logic [7:0] a, input logic [7:0] exp);
        qe.push_back(exp);
        pmc_host_inst.rd(a);
    endtask
    task automatic pulse(input int f);
        @(posedge clk);
        evt <= pmc_evt_s'(5'h01 << f);
        @(posedge clk);
        evt <= '0;
        #1;
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Read results are due only in the cycle after the strobe
    always @(posedge clk) rd_d <= rd;
    always @(negedge clk)
    begin
        if (rd_d)
            check("rdata", rdata, qe.pop_front());
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            summarize();
        end
    end
    initial
    begin
        r0 = 8'($urandom(32'h378e));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rdx(PMC_ADDR_ON_TIME_B_LO, 8'h01);
        rdx(PMC_ADDR_ON_TIME_B_HI, 8'h00);
        rdx(PMC_ADDR_EXT_CMD, 8'h00);
        rdx(PMC_ADDR_CMC_SECOND, 8'h04);
        rdx(8'h00, 8'h00);
        $display("reset values done");
        r0 = 8'($urandom());
        r1 = 8'($urandom());
        pmc_host_inst.wr(PMC_ADDR_ON_TIME_B_LO, r0);
        pmc_host_inst.wr(PMC_ADDR_ON_TIME_B_HI, r1);
        pmc_host_inst.wr(PMC_ADDR_CMC_SECOND, r1);
        rdx(PMC_ADDR_ON_TIME_B_LO, r0);
        rdx(PMC_ADDR_ON_TIME_B_HI, r1 & 8'h3f);
        rdx(PMC_ADDR_CMC_SECOND, r1 & 8'h3f);
        $display("read back done");
        for (int s = 0; s < 2; s++)
        begin
            pmc_host_inst.wr(PMC_ADDR_CTRL, s ? 8'h0c : 8'h00);
            pmc_host_inst.wr(PMC_ADDR_EXT_CMD, 8'h0c);
            #1;
            check("gain_freeze", {7'h0, gfrz}, 8'(s));
            check("freq_freeze", {7'h0, ffrz}, 8'(s));
            rdx(PMC_ADDR_EXT_CMD, 8'h0c);
            pmc_host_inst.wr(PMC_ADDR_EXT_CMD, 8'h00);
            #1;
            check("gain_release", {7'h0, gfrz}, 8'h00);
        end
        $display("freeze done");
        pmc_host_inst.wr(PMC_ADDR_CMC_SECOND, 8'h00);
        for (int e = 0; e < 4; e++)
        begin
            pmc_host_inst.wr(PMC_ADDR_CTRL, 8'(e << 4));
            pmc_host_inst.wr(PMC_ADDR_EXT_CMD, 8'h03);
            #1;
            check("forced_timeout", {7'h0, to_ev}, 8'(e == 1 || e == 2));
            if (e < 3)
                check("forced_msg_end", {7'h0, me_ev}, 8'(e != 0));
            rdx(PMC_ADDR_EXT_CMD, 8'h00);
        end
        $display("forced events done");
        for (int b = 0; b < 2; b++)
        begin
            pmc_host_inst.wr(PMC_ADDR_CMC_SECOND, b ? 8'h0c : 8'h00);
            pulse(1);
            check("frame_init", {7'h0, finit}, 8'(b));
            pulse(0);
            check("cycle_init", {7'h0, finit}, 8'(b));
            pulse(3);
            check("timeout_pass", {7'h0, to_ev}, 8'h01);
        end
        $display("fifo init done");
        pmc_host_inst.wr(PMC_ADDR_CTRL, 8'h10);
        pmc_host_inst.wr(PMC_ADDR_CMC_SECOND, 8'h02);
        pmc_host_inst.wr(PMC_ADDR_EXT_CMD, 8'h01);
        @(posedge clk);
        #1;
        check("fifo_lock", {7'h0, flock}, 8'h01);
        pmc_host_inst.wr(PMC_ADDR_CTRL, 8'h50);
        @(posedge clk);
        #1;
        check("fifo_unlock", {7'h0, flock}, 8'h00);
        $display("lock done");
        for (int x = 0; x < 2; x++)
        begin
            pmc_host_inst.wr(PMC_ADDR_CMC_SECOND, 8'(x));
            sleep <= 1'b1;
            @(posedge clk);
            #1;
            check("xtal_sleep", {7'h0, xtal}, 8'(x));
            check("rx_on_sleep", {7'h0, rx_on}, 8'h00);
            sleep <= 1'b0;
            @(posedge clk);
            #1;
            check("xtal_awake", {7'h0, xtal}, 8'h01);
            check("rx_on_awake", {7'h0, rx_on}, 8'h01);
        end
        $display("crystal done");
        pmc_host_inst.wr(PMC_ADDR_REF_TIMER, 8'h01);
        pmc_host_inst.wr(PMC_ADDR_ON_TIME_B_LO, 8'h02);
        pmc_host_inst.wr(PMC_ADDR_ON_TIME_B_HI, 8'h00);
        for (int m = 0; m < 2; m++)
        begin
            pmc_host_inst.wr(PMC_ADDR_CTRL, m ? 8'h03 : 8'h01);
            seen_b = 0;
            repeat (1000)
            begin
                @(negedge clk);
                if (cfg_b === 1'b1)
                    seen_b = 1;
            end
            check("config_b_seen", 8'(seen_b), 8'(m));
        end
        $display("self polling done");
        pmc_host_inst.wr(PMC_ADDR_CMC_SECOND, 8'h38);
        for (int k = 0; k < 4; k++)
        begin
            if (k == 2)
                pmc_host_inst.wr(PMC_ADDR_CMC_SECOND, 8'h08);
            pulse(2);
            check("wake_init", {7'h0, finit}, 8'h01);
            seen_b = int'(cfg_b);
            pulse(k[0] ? 3 : 4);
            @(posedge clk);
            #1;
            if (k[0])
                check("after_timeout", {7'h0, cfg_b}, k < 2 ? 8'(!seen_b) : 8'h00);
            else
                check("after_msg_end", {7'h0, cfg_b}, k < 2 ? 8'(!seen_b) : 8'h00);
        end
        $display("run phase done");
        summarize();
    end
endmodule
bind pmc_regs pmc_regs_props pmc_regs_props_inst (.CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I),
    .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .EVT_I(EVT_I), .SLEEP_I(SLEEP_I), .TIMEOUT_EVENT_O(TIMEOUT_EVENT_O),
    .MESSAGE_END_EVENT_O(MESSAGE_END_EVENT_O), .GAIN_FREEZE_O(GAIN_FREEZE_O),
    .FIFO_INIT_O(FIFO_INIT_O), .FIFO_LOCK_O(FIFO_LOCK_O), .XTAL_HP_O(XTAL_HP_O));
`default_nettype wire
